//--- inc/llut_params.svh
// Constants for the logic-level UART terminal block.
// Assumes a 25 MHz system clock; included by the package, the UART and the top-level test bench file.
// Overview of operation
// RL1: The port sends and receives at the same time at any baud rate from 150 to 38400.
// RL2: Every character carries eight data bits, no parity and one stop bit, with no other format.
// RL3: Start bits are low and stop bits are high on both lines, with no inversion.
// RL4: Data leaves on the transmit line to the target and is sampled from the receive line.
// RL5: The busy lamp lights while characters are sent or received.
// RL6: Lines idle high, data goes least significant bit first, one baud period per bit.
`ifndef LLUT_PARAMS_SVH
`define LLUT_PARAMS_SVH
`define LLUT_CLK_HZ        25000000
`define LLUT_BAUD_MIN      150
`define LLUT_BAUD_MAX      38400
`define LLUT_DATA_BITS     8
`define LLUT_CNT_W         20
`define LLUT_BAUD_W        16
`define LLUT_FIFO_DEPTH    16
`define LLUT_LAMP_HOLD     20'h186a0
`define LLUT_DIV_DEFAULT   20'h00a2c
`endif

//--- inc/llut_pkg.sv
// Types for the logic-level UART terminal block.
// Assumes llut_params.svh is on the include path.
`include "llut_params.svh"
package llut_pkg;
    typedef enum logic [1:0] {LLUT_IDLE, LLUT_START, LLUT_DATA, LLUT_STOP} llut_state_type;
    typedef logic [`LLUT_DATA_BITS-1:0] llut_byte_type;
    typedef logic [`LLUT_CNT_W-1:0]     llut_cnt_type;
endpackage

//--- verilog/llut_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module llut_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    output logic [WIDTH-1:0]      o_rd_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    wp_d;
    logic [AW-1:0]    rp_q;
    logic [AW-1:0]    rp_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             do_wr;
    logic             do_rd;

    always_comb
    begin
        do_wr = i_wr_valid && (cnt_q != (AW+1)'(DEPTH));
        do_rd = i_rd_ready && (cnt_q != '0);
        wp_d  = do_wr ? wp_q + 1'b1 : wp_q;
        rp_d  = do_rd ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        if (do_wr)
            mem_q[wp_q] <= i_wr_data;
    end

    assign o_wr_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_rd_valid = (cnt_q != '0);
    assign o_rd_data  = mem_q[rp_q];
endmodule

//--- verilog/llut_uart.sv
// Full-duplex 8N1 UART at logic levels with busy lamp and transmit FIFO.
// Assumes i_clk at 25 MHz; i_rx comes from the target pin, asynchronous.
`timescale 1ns/1ps
`include "llut_params.svh"
module llut_uart (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic [`LLUT_CNT_W-1:0] i_baud_div,
    input  wire llut_pkg::llut_byte_type i_tx_data,
    input  wire logic                  i_tx_valid,
    output logic                       o_tx_ready,
    output logic                       o_tx,
    input  wire logic                  i_rx,
    output llut_pkg::llut_byte_type    o_rx_data,
    output logic                       o_rx_valid,
    output logic                       o_busy_led
);
    import llut_pkg::*;

    logic         rx_meta_q;
    logic         rx_sync_q;
    logic         rx_prev_q;
    llut_byte_type f_data;
    logic         f_valid;
    logic         f_ready;
    logic         f_wr_ready;
    llut_cnt_type div_q;

    llut_fifo #(.WIDTH(`LLUT_DATA_BITS), .DEPTH(`LLUT_FIFO_DEPTH)) u_fifo (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_wr_data  (i_tx_data),
        .i_wr_valid (i_tx_valid && o_tx_ready),
        .o_wr_ready (f_wr_ready),
        .o_rd_data  (f_data),
        .o_rd_valid (f_valid),
        .i_rd_ready (f_ready)
    );

    // Transmit side
    llut_state_type tx_st_q;
    llut_state_type tx_st_d;
    llut_cnt_type   tx_cnt_q;
    llut_cnt_type   tx_cnt_d;
    logic [2:0]     tx_bit_q;
    logic [2:0]     tx_bit_d;
    llut_byte_type  tx_sh_q;
    llut_byte_type  tx_sh_d;
    logic           tx_q;
    logic           tx_d;

    always_comb
    begin
        tx_st_d  = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d  = tx_sh_q;
        tx_d     = tx_q;
        f_ready  = 1'b0;
        case (tx_st_q)
            LLUT_IDLE:
            begin
                tx_d = 1'b1; // RL6
                if (f_valid)
                begin
                    f_ready  = 1'b1;
                    tx_sh_d  = f_data;
                    tx_d     = 1'b0; // RL3
                    tx_cnt_d = div_q - 1'b1;
                    tx_st_d  = LLUT_START;
                end
            end
            LLUT_START, LLUT_DATA:
            begin
                if (tx_cnt_q == '0)
                begin
                    tx_cnt_d = div_q - 1'b1;
                    if (tx_st_q == LLUT_START)
                    begin
                        tx_d     = tx_sh_q[0]; // RL6
                        tx_bit_d = 3'h0;
                        tx_st_d  = LLUT_DATA;
                    end
                    else if (tx_bit_q == 3'h7) // RL2
                    begin
                        tx_d    = 1'b1; // RL3
                        tx_st_d = LLUT_STOP;
                    end
                    else
                    begin
                        tx_d     = tx_sh_q[tx_bit_q + 3'h1];
                        tx_bit_d = tx_bit_q + 3'h1;
                    end
                end
                else
                    tx_cnt_d = tx_cnt_q - 1'b1;
            end
            LLUT_STOP:
            begin
                if (tx_cnt_q == '0)
                    tx_st_d = LLUT_IDLE;
                else
                    tx_cnt_d = tx_cnt_q - 1'b1;
            end
            default: tx_st_d = LLUT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            tx_st_q  <= LLUT_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= 3'h0;
            tx_sh_q  <= '0;
            tx_q     <= 1'b1;
        end
        else
        begin
            tx_st_q  <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q  <= tx_sh_d;
            tx_q     <= tx_d;
        end
    end

    // Receive side, mid-bit sampling
    llut_state_type rx_st_q;
    llut_state_type rx_st_d;
    llut_cnt_type   rx_cnt_q;
    llut_cnt_type   rx_cnt_d;
    logic [2:0]     rx_bit_q;
    logic [2:0]     rx_bit_d;
    llut_byte_type  rx_sh_q;
    llut_byte_type  rx_sh_d;
    llut_byte_type  rx_out_q;
    llut_byte_type  rx_out_d;
    logic           rx_vld_q;
    logic           rx_vld_d;

    always_comb
    begin
        rx_st_d  = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d  = rx_sh_q;
        rx_out_d = rx_out_q;
        rx_vld_d = 1'b0;
        case (rx_st_q)
            LLUT_IDLE:
                if (rx_prev_q && !rx_sync_q) // RL3
                begin
                    rx_cnt_d = {1'b0, div_q[`LLUT_CNT_W-1:1]} - 1'b1;
                    rx_st_d  = LLUT_START;
                end
            LLUT_START:
                if (rx_cnt_q == '0)
                begin
                    // Glitch shorter than half a bit is dropped
                    rx_cnt_d = div_q - 1'b1;
                    rx_bit_d = 3'h0;
                    rx_st_d  = rx_sync_q ? LLUT_IDLE : LLUT_DATA;
                end
                else
                    rx_cnt_d = rx_cnt_q - 1'b1;
            LLUT_DATA:
                if (rx_cnt_q == '0)
                begin
                    rx_cnt_d = div_q - 1'b1;
                    rx_sh_d  = {rx_sync_q, rx_sh_q[7:1]}; // RL6
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == 3'h7) // RL2
                        rx_st_d = LLUT_STOP;
                end
                else
                    rx_cnt_d = rx_cnt_q - 1'b1;
            LLUT_STOP:
                if (rx_cnt_q == '0)
                begin
                    // Framing error: byte discarded when stop bit is low
                    if (rx_sync_q) // RL3
                    begin
                        rx_out_d = rx_sh_q;
                        rx_vld_d = 1'b1;
                    end
                    rx_st_d = LLUT_IDLE;
                end
                else
                    rx_cnt_d = rx_cnt_q - 1'b1;
            default: rx_st_d = LLUT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
            rx_st_q   <= LLUT_IDLE;
            rx_cnt_q  <= '0;
            rx_bit_q  <= 3'h0;
            rx_sh_q   <= '0;
            rx_out_q  <= '0;
            rx_vld_q  <= 1'b0;
        end
        else
        begin
            rx_meta_q <= i_rx; // RL4
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
            rx_st_q   <= rx_st_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            rx_out_q  <= rx_out_d;
            rx_vld_q  <= rx_vld_d;
        end
    end

    // Divider latched only while both sides idle; lamp stretched
    llut_cnt_type div_d;
    llut_cnt_type lamp_q;
    llut_cnt_type lamp_d;
    logic         led_q;
    logic         led_d;
    logic         wr_rdy_q;
    logic         active;
    logic [4:0]   occ_q;
    logic [4:0]   occ_d;
    logic         wr_rdy_d;

    always_comb
    begin
        active = (tx_st_q != LLUT_IDLE) || (rx_st_q != LLUT_IDLE);
        div_d  = div_q;
        if (!active && (i_baud_div >= `LLUT_CNT_W'(`LLUT_CLK_HZ / `LLUT_BAUD_MAX))
                && (i_baud_div <= `LLUT_CNT_W'(`LLUT_CLK_HZ / `LLUT_BAUD_MIN))) // RL1
            div_d = i_baud_div;
        lamp_d = active ? `LLUT_LAMP_HOLD : (lamp_q != '0 ? lamp_q - 1'b1 : lamp_q);
        led_d  = active || (lamp_q != '0); // RL5
        occ_d    = occ_q + 5'(i_tx_valid && wr_rdy_q) - 5'(f_ready);
        wr_rdy_d = (occ_d != 5'(`LLUT_FIFO_DEPTH));
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            div_q    <= `LLUT_DIV_DEFAULT;
            lamp_q   <= '0;
            led_q    <= 1'b0;
            wr_rdy_q <= 1'b0;
            occ_q    <= 5'h00;
        end
        else
        begin
            div_q    <= div_d;
            lamp_q   <= lamp_d;
            led_q    <= led_d;
            wr_rdy_q <= wr_rdy_d;
            occ_q    <= occ_d;
        end
    end

    // Shadow count keeps ready a plain flop; it follows the FIFO count exactly
    assign o_tx_ready = wr_rdy_q;
    assign o_tx       = tx_q; // RL4
    assign o_rx_data  = rx_out_q;
    assign o_rx_valid = rx_vld_q;
    assign o_busy_led = led_q;

    sequence tx_start_s;
        tx_st_q == LLUT_IDLE && f_valid;
    endsequence

    tx_start_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
        tx_start_s |=> !o_tx) else $error("start bit not low");
    tx_idle_high_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL6
        $past(tx_st_q) == LLUT_IDLE && tx_st_q == LLUT_IDLE |-> o_tx)
        else $error("tx line not idle high");
    tx_stop_high_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
        tx_st_q == LLUT_STOP |-> o_tx) else $error("stop bit not high");
    rx_frame_ok_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
        o_rx_valid |-> $past(rx_sync_q)) else $error("byte taken with low stop");
    busy_lamp_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL5
        active |=> o_busy_led) else $error("lamp dark during activity");
    baud_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL1
        div_q >= `LLUT_CNT_W'(`LLUT_CLK_HZ / `LLUT_BAUD_MAX)) else $error("divider too small");
    div_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL1
        active |=> $stable(div_q)) else $error("divider changed mid character");
    tx_bit_time_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL6
        $changed(o_tx) |-> $past(tx_cnt_q) == '0 || $past(tx_st_q) == LLUT_IDLE)
        else $error("tx bit cut short");
    tx_ready_room_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL1
        o_tx_ready |-> f_wr_ready) else $error("ready offered while fifo full");
endmodule

//--- testbench/llut_target_model.sv
// Model of the target controller's serial port, 8N1 at logic levels.
// Assumes the bench sets bit_div to the divider that it gives the device.
`timescale 1ns/1ps
module llut_target_model (
    input  wire logic i_clk,
    input  wire logic i_line,
    output logic      o_line
);
    logic [7:0] got_q[$];
    logic [7:0] mon_b;
    logic       frame_ok;
    int         bit_div;
    initial
    begin
        o_line = 1'b1;
        frame_ok = 1'b1;
        bit_div = 651;
    end
    // Target transmit; a low stop bit is sent only on request
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge i_clk);
            o_line <= f[i];
            repeat (bit_div - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_line <= 1'b1;
    endtask
    // Target receive, sampled mid bit like a real port
    always
    begin
        @(negedge i_line);
        repeat (bit_div / 2) @(posedge i_clk);
        if (i_line !== 1'b0) frame_ok = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_div) @(posedge i_clk);
            mon_b[i] = i_line;
        end
        repeat (bit_div) @(posedge i_clk);
        if (i_line !== 1'b1) frame_ok = 1'b0;
        got_q.push_back(mon_b);
    end
endmodule

//--- testbench/logic_level_uart_terminal_test.sv
// Self-checking bench for the UART terminal: tx FIFO fill, full duplex traffic.
// Assumes llut_target_model on the serial pins and a 25 MHz clock.
`timescale 1ns/1ps
`include "llut_params.svh"
module logic_level_uart_terminal_test;
    import llut_pkg::*;
    localparam int DIV = 651;
    logic                   i_clk;
    logic                   i_sys_rst;
    logic [`LLUT_CNT_W-1:0] i_baud_div;
    llut_byte_type          i_tx_data;
    logic                   i_tx_valid;
    logic                   o_tx_ready;
    logic                   o_tx;
    logic                   i_rx;
    llut_byte_type          o_rx_data;
    logic                   o_rx_valid;
    logic                   o_busy_led;
    logic [15:0]            seed;
    logic [7:0]             tx_exp[$];
    logic [7:0]             rx_exp[$];
    logic [7:0]             corner[3] = '{8'h01, 8'h80, 8'h5a};
    int                     n_errors;
    int                     compares;
    int                     cycles;
    llut_uart llut_uart_inst (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_baud_div (i_baud_div),
        .i_tx_data  (i_tx_data),
        .i_tx_valid (i_tx_valid),
        .o_tx_ready (o_tx_ready),
        .o_tx       (o_tx),
        .i_rx       (i_rx),
        .o_rx_data  (o_rx_data),
        .o_rx_valid (o_rx_valid),
        .o_busy_led (o_busy_led)
    );
    llut_target_model tgt_inst (
        .i_clk  (i_clk),
        .i_line (o_tx),
        .o_line (i_rx)
    );
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Counts: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Sends a byte from the target; a bad stop byte is not expected back
    task automatic rx_byte(input logic [7:0] b, input logic stop);
        if (stop) rx_exp.push_back(b);
        tgt_inst.send(b, stop);
        if (!stop) repeat (2 * DIV) @(posedge i_clk);
    endtask
    // Offers one byte, held until ready is seen high; call at a clock edge
    task automatic tx_byte(input logic [7:0] b);
        i_tx_data  <= b;
        i_tx_valid <= 1'b1;
        @(posedge i_clk);
        while (o_tx_ready !== 1'b1) @(posedge i_clk);
        tx_exp.push_back(b);
        i_tx_valid <= 1'b0;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Hang guard: the whole run needs about 61000 cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            n_errors++;
            close_out();
        end
    end
    always @(posedge i_clk)
        if (o_rx_valid === 1'b1)
        begin
            if (rx_exp.size() == 0) check(8'h00, 8'h01, "unexpected rx byte");
            else check(o_rx_data, rx_exp.pop_front(), "rx byte");
        end
    initial
    begin
        i_sys_rst = 1'b1;
        i_baud_div = 20'(DIV);
        i_tx_data = 8'h00;
        i_tx_valid = 1'b0;
        seed = 16'(20094);
        n_errors = 0;
        compares = 0;
        cycles = 0;
        tgt_inst.bit_div = DIV;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        check({7'h00, o_tx}, 8'h01, "idle line");
        check({7'h00, o_busy_led}, 8'h00, "lamp after reset");
        // Fill the FIFO back to back until it refuses
        i_tx_data  <= 8'h00;
        i_tx_valid <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge i_clk);
            if (o_tx_ready !== 1'b1) break;
            tx_exp.push_back(i_tx_data);
            seed = lfsr_next(seed);
            i_tx_data <= (i == 0) ? 8'hff : seed[7:0];
        end
        i_tx_valid <= 1'b0;
        check(8'(tx_exp.size() >= 16 && tx_exp.size() <= 18), 8'h01, "fifo depth");
        // First byte out, then reset inside its stop bit to flush the rest
        for (int k = 0; k < 8000 && tgt_inst.got_q.size() == 0; k++)
            @(posedge i_clk);
        check(tgt_inst.got_q[0], tx_exp[0], "first tx byte");
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        tgt_inst.got_q.delete();
        tx_exp.delete();
        repeat (2) @(posedge i_clk);
        check({7'h00, o_tx}, 8'h01, "idle after reset");
        check({7'h00, o_busy_led}, 8'h00, "lamp after second reset");
        check({7'h00, o_tx_ready}, 8'h01, "ready after reset");
        // Out-of-range divider must be ignored; traffic below stays at DIV
        i_baud_div <= 20'h00010;
        // Receive and transmit at the same time
        fork
            begin
                foreach (corner[k])
                    rx_byte(corner[k], 1'b1);
                rx_byte(8'h3c, 1'b0);
                for (int k = 0; k < 4; k++)
                begin
                    seed = lfsr_next(seed);
                    rx_byte(seed[7:0], 1'b1);
                end
            end
            begin
                for (int k = 0; k < 4; k++)
                begin
                    seed = lfsr_next(seed);
                    tx_byte(seed[7:0]);
                    @(posedge i_clk);
                end
                repeat (3 * DIV) @(posedge i_clk);
                check({7'h00, o_busy_led}, 8'h01, "lamp while active");
                for (int k = 0; k < 60000 && tgt_inst.got_q.size() < tx_exp.size(); k++)
                    @(posedge i_clk);
            end
        join
        repeat (2 * DIV) @(posedge i_clk);
        check(8'(tgt_inst.got_q.size()), 8'(tx_exp.size()), "tx count");
        foreach (tx_exp[k])
            check(tgt_inst.got_q[k], tx_exp[k], "tx byte order");
        check({7'h00, tgt_inst.frame_ok}, 8'h01, "tx framing");
        check({7'h00, o_tx}, 8'h01, "line idles high");
        check(8'(rx_exp.size()), 8'h00, "rx bytes missing");
        close_out();
    end
endmodule
